/* File: hdl/pcd_defs.svh */
// Register offsets, field positions, reset values and timing counts
// for the cable diagnostic register bank. Definitions only.
`ifndef PCD_DEFS_SVH
`define PCD_DEFS_SVH

// Word indices; the byte address carries them in bits 5:2
`define PCD_IDX_CABLE     4'h0
`define PCD_IDX_PHYCTRL   4'h2
`define PCD_IDX_ALIAS     4'h4
`define PCD_IDX_IRQSTAT   4'h6
`define PCD_IDX_IRQMASK   4'h7

// Primary cable test view
`define PCD_CT_START      15
`define PCD_CT_RES_HI     14
`define PCD_CT_RES_LO     13
`define PCD_CT_SHORT      12
`define PCD_CT_CNT_HI     8

// Special control view
`define PCD_PC_POLREV     5
`define PCD_PC_XOVER      4
`define PCD_PC_FORCE      3
`define PCD_PC_PWRSAVE    2
`define PCD_PC_LOOP       1

// Alias view
`define PCD_AL_SHORT      15
`define PCD_AL_RES_HI     14
`define PCD_AL_RES_LO     13
`define PCD_AL_START      12
`define PCD_AL_FORCE      11
`define PCD_AL_PWRSAVE    10
`define PCD_AL_LOOP       9

// Interrupt bits
`define PCD_IRQ_DONE      0
`define PCD_IRQ_POLCHG    1
`define PCD_IRQ_XOVCHG    2

// Reset values
`define PCD_RST_PWRSAVE   1'b1
`define PCD_RST_FORCE     1'b0
`define PCD_RST_LOOP      1'b0

// Test watchdog: a measurement that never answers is reported as failed
`define PCD_TEST_TIMEOUT_US 100
`define PCD_CLK_MHZ         250

`endif

/* File: hdl/pcd_pkg.sv */
// Types for the cable diagnostic register bank.
// Assumes nothing beyond the defs header.
package pcd_pkg;
  typedef enum logic [1:0] {PCD_NORMAL, PCD_OPEN, PCD_SHORT, PCD_FAILED} pcd_result_e;
  typedef enum logic [1:0] {PCD_IDLE, PCD_RUN, PCD_DONE} pcd_state_e;
endpackage

/* File: hdl/pcd_regs.sv */
// Cable diagnostic and PHY special control register bank, Wishbone slave.
// Assumes an analog measurement engine outside that answers a start pulse
// with a done pulse and its results, and PHY status levels from pins.
`timescale 1ns/1ns
`default_nettype none
`include "pcd_defs.svh"
module pcd_regs #(
  parameter int TEST_TIMEOUT_CYC = `PCD_TEST_TIMEOUT_US * `PCD_CLK_MHZ
) (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // Wishbone classic slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [5:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // Measurement engine
  output logic                     testStart,
  input  wire logic                testDone,
  input  wire pcd_pkg::pcd_result_e testResult,
  input  wire logic                testNearShort,
  input  wire logic [8:0]          testFaultCount,
  // PHY status pins
  input  wire logic                polarityReversed,
  input  wire logic                crossoverState,
  // PHY controls
  output logic                     forceLinkPass,
  output logic                     powerSaveDisable,
  output logic                     lineLoopback,
  // Interrupt
  output logic                     irq
);
  import pcd_pkg::*;

  localparam int TOW = $clog2(TEST_TIMEOUT_CYC + 1);

  pcd_state_e  state_r;
  pcd_result_e result_r;
  logic        nearShort_r;
  logic [8:0]  faultCount_r;
  logic [TOW-1:0] timer_r;
  logic [2:0]  irqStat_r;
  logic [2:0]  irqMask_r;
  logic [1:0]  phySync;
  logic [1:0]  phyPrev_r;
  logic        startBit;
  logic        acc;
  logic        wrLo;
  logic [3:0]  idx;
  logic        wrCable;
  logic        wrCtrl;
  logic        wrAlias;
  logic        startReq;
  logic        testEnd;
  logic        timedOut;
  logic [2:0]  irqEvt;
  logic [31:0] rdData;
  logic        wrLand;
  pcd_state_e  state_nxt;
  pcd_result_e result_nxt;
  logic        nearShort_nxt;
  logic [8:0]  faultCount_nxt;
  logic [TOW-1:0] timer_nxt;
  logic [2:0]  irqStat_nxt;
  logic [2:0]  irqMask_nxt;
  logic [2:0]  ctl_nxt;

  // Word index match, shared by every write decode
  function automatic logic regHit(
    input logic [3:0] at,
    input logic [3:0] want
  );
    return at == want;
  endfunction

  // Control triple out of a written word; both views share the flops
  function automatic logic [2:0] ctlField(
    input logic [31:0] data,
    input logic        viaAlias
  );
    if (viaAlias)
      return {data[`PCD_AL_FORCE], data[`PCD_AL_PWRSAVE], data[`PCD_AL_LOOP]};
    else
      return {data[`PCD_PC_FORCE], data[`PCD_PC_PWRSAVE], data[`PCD_PC_LOOP]};
  endfunction

  // Pin levels cross into clk_sys
  pcd_sync2 #(
    .WIDTH (2)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .asyncIn ({crossoverState, polarityReversed}),
    .syncOut (phySync)
  );

  // Bus decode; ack answers one cycle after the request, then drops
  // Writes land on the ack edge, while the master still holds its data
  assign acc     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wrLand  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
  assign idx     = wb_adr_i[5:2];
  assign wrLo    = wrLand && (wb_sel_i[1:0] == 2'h3);
  assign wrCable = wrLo && regHit(idx, `PCD_IDX_CABLE);
  assign wrCtrl  = wrLo && regHit(idx, `PCD_IDX_PHYCTRL);
  assign wrAlias = wrLo && regHit(idx, `PCD_IDX_ALIAS);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= acc;
  end

  // Start through either view
  assign startReq = (wrCable && wb_dat_i[`PCD_CT_START])
                  || (wrAlias && wb_dat_i[`PCD_AL_START]);
  assign startBit = (state_r == PCD_RUN);
  assign timedOut = (timer_r == TOW'(TEST_TIMEOUT_CYC));
  assign testEnd  = (state_r == PCD_RUN) && (testDone || timedOut);

  // Test sequencer; a start during a run is ignored
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      PCD_IDLE, PCD_DONE:
        if (startReq)
          state_nxt = PCD_RUN;
      PCD_RUN:
        if (testEnd)
          state_nxt = PCD_DONE;
      default:
        state_nxt = PCD_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      state_r <= PCD_IDLE;
    else
      state_r <= state_nxt;
  end

  // Engine start is a one-cycle pulse
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      testStart <= 1'b0;
    else
      testStart <= startReq && (state_r != PCD_RUN);
  end

  // Watchdog so a silent engine cannot hang the start bit
  always_comb
  begin
    timer_nxt = timer_r;
    if (state_r != PCD_RUN)
      timer_nxt = '0;
    else if (!timedOut)
      timer_nxt = timer_r + TOW'(1);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      timer_r <= '0;
    else
      timer_r <= timer_nxt;
  end

  // Timeout reports a failed test with no distance
  always_comb
  begin
    result_nxt     = PCD_FAILED;
    nearShort_nxt  = 1'b0;
    faultCount_nxt = 9'h000;
    if (testDone)
    begin
      result_nxt     = testResult;
      nearShort_nxt  = testNearShort && (testResult == PCD_SHORT);
      faultCount_nxt = testFaultCount;
    end
  end

  // Results latched at test end
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      result_r     <= PCD_NORMAL;
      nearShort_r  <= 1'b0;
      faultCount_r <= 9'h000;
    end
    else if (testEnd)
    begin
      result_r     <= result_nxt;
      nearShort_r  <= nearShort_nxt;
      faultCount_r <= faultCount_nxt;
    end
  end

  // Controls shared by both views
  always_comb
  begin
    ctl_nxt = {forceLinkPass, powerSaveDisable, lineLoopback};
    if (wrCtrl || wrAlias)
      ctl_nxt = ctlField(wb_dat_i, wrAlias);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      forceLinkPass    <= `PCD_RST_FORCE;
      powerSaveDisable <= `PCD_RST_PWRSAVE;
      lineLoopback     <= `PCD_RST_LOOP;
    end
    else
    begin
      forceLinkPass    <= ctl_nxt[2];
      powerSaveDisable <= ctl_nxt[1];
      lineLoopback     <= ctl_nxt[0];
    end
  end

  // Interrupt events: test done, polarity change, crossover change
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      phyPrev_r <= 2'h0;
    else
      phyPrev_r <= phySync;
  end

  // Either pin level changing is an event; test end is the third
  always_comb
  begin
    irqEvt                  = 3'h0;
    irqEvt[`PCD_IRQ_DONE]   = testEnd;
    irqEvt[`PCD_IRQ_POLCHG] = phySync[0] ^ phyPrev_r[0];
    irqEvt[`PCD_IRQ_XOVCHG] = phySync[1] ^ phyPrev_r[1];
  end

  // Set wins over write-one-to-clear
  always_comb
  begin
    irqStat_nxt = irqStat_r;
    if (wrLand && wb_sel_i[0] && regHit(idx, `PCD_IDX_IRQSTAT))
      irqStat_nxt = irqStat_r & ~wb_dat_i[2:0];
    irqStat_nxt = irqStat_nxt | irqEvt;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      irqStat_r <= 3'h0;
    else
      irqStat_r <= irqStat_nxt;
  end

  // Mask gates only the output; status still records every event
  always_comb
  begin
    irqMask_nxt = irqMask_r;
    if (wrLand && wb_sel_i[0] && regHit(idx, `PCD_IDX_IRQMASK))
      irqMask_nxt = wb_dat_i[2:0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      irqMask_r <= 3'h0;
    else
      irqMask_r <= irqMask_nxt;
  end

  assign irq = |(irqStat_r & irqMask_r);

  // Read mux; reserved and unmapped read zero
  always_comb
  begin
    rdData = 32'h0000_0000;
    unique case (idx)
      `PCD_IDX_CABLE:
      begin
        rdData[`PCD_CT_START]                 = startBit;
        rdData[`PCD_CT_RES_HI:`PCD_CT_RES_LO] = result_r;
        rdData[`PCD_CT_SHORT]                 = nearShort_r;
        rdData[`PCD_CT_CNT_HI:0]              = faultCount_r;
      end
      `PCD_IDX_PHYCTRL:
      begin
        rdData[`PCD_PC_POLREV]  = phySync[0];
        rdData[`PCD_PC_XOVER]   = phySync[1];
        rdData[`PCD_PC_FORCE]   = forceLinkPass;
        rdData[`PCD_PC_PWRSAVE] = powerSaveDisable;
        rdData[`PCD_PC_LOOP]    = lineLoopback;
      end
      `PCD_IDX_ALIAS:
      begin
        rdData[`PCD_AL_SHORT]                 = nearShort_r;
        rdData[`PCD_AL_RES_HI:`PCD_AL_RES_LO] = result_r;
        rdData[`PCD_AL_START]                 = startBit;
        rdData[`PCD_AL_FORCE]                 = forceLinkPass;
        rdData[`PCD_AL_PWRSAVE]               = powerSaveDisable;
        rdData[`PCD_AL_LOOP]                  = lineLoopback;
        rdData[`PCD_CT_CNT_HI:0]              = faultCount_r;
      end
      `PCD_IDX_IRQSTAT:
        rdData[2:0] = irqStat_r;
      `PCD_IDX_IRQMASK:
        rdData[2:0] = irqMask_r;
      default:
        rdData = 32'h0000_0000;
    endcase
  end

  // Read data registered with the ack
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      wb_dat_o <= 32'h0000_0000;
    else if (acc)
      wb_dat_o <= rdData;
  end
endmodule
`default_nettype wire

/* File: hdl/pcd_sync2.sv */
// Two flip-flop synchroniser for a bus of levels.
// Assumes inputs are quasi-static levels from outside clk_sys.
`timescale 1ns/1ns
`default_nettype none
module pcd_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Levels
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_r;

  // First stage feeds only the second
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      stage1_r <= '0;
      syncOut  <= '0;
    end
    else
    begin
      stage1_r <= asyncIn;
      syncOut  <= stage1_r;
    end
  end
endmodule
`default_nettype wire

/* File: tb/pcd_regs_bench.sv */
// Self-checking bench for the cable diagnostic register bank.
// Drives bus, engine and pin inputs itself; no partner model.
`timescale 1ns/1ns
`default_nettype none
module phy_cable_diag_ctrl_regs_bench;
  import pcd_pkg::*;
  logic        clk_sys = 0, rst = 1, cyc = 0, stb = 0, we = 0, done = 0, ns = 0, pol = 0, xov = 0;
  logic [5:0]  adr = 0;
  logic [3:0]  sel = 0;
  logic [2:0]  ctl;
  logic [31:0] wdat = 0, rdat, rnd = 32'h0D46BCF0;
  logic [8:0]  cnt = 0;
  pcd_result_e res = PCD_NORMAL;
  wire logic [31:0] dato;
  wire logic   ack, start, frc, pws, lpb, irq;
  int          errTotal = 0, compares = 0, cycles = 0, starts = 0;
  pcd_regs #(.TEST_TIMEOUT_CYC(50)) uut (.clk_sys, .rst, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack), .testStart(start),
    .testDone(done), .testResult(res), .testNearShort(ns), .testFaultCount(cnt), .polarityReversed(pol),
    .crossoverState(xov), .forceLinkPass(frc), .powerSaveDisable(pws), .lineLoopback(lpb), .irq);
  always #2 clk_sys = ~clk_sys;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      errTotal++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Ack sampled at the edge, so no race with the slave
  task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    int n = 0;
    @(posedge clk_sys);
    {cyc, stb, we, adr, wdat, sel} <= {2'h3, w, a, d, s};
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    chk("ack", 32'h1, {31'h0, ack});
    rdat = dato;
    {cyc, stb} <= 2'h0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input string nm);
    bus(a, 1'b0, 32'h0, 4'hF);
    chk(nm, e, rdat);
  endtask
  task automatic end_of_test;
    $display("counts: %0d compares, %0d mismatches", compares, errTotal);
    if (errTotal == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cycles++;
    if (start === 1'b1)
      starts++;
    if (cycles == 3000)
    begin
      errTotal++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    rd(6'h08, 32'h4, "ctrl reset");
    rd(6'h10, 32'h400, "alias reset");
    rd(6'h00, 32'h0, "cable reset");
    rd(6'h20, 32'h0, "unmapped");
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      {pol, xov} <= rnd[17:16];
      bus(6'h08, 1'b1, rnd, 4'h3);
      rd(6'h10, {20'h0, rnd[3:1], 9'h0}, "alias ctl");
      ctl = rnd[11:9];
      bus(6'h10, 1'b1, {rnd[31:13], 1'b0, rnd[11:0]}, 4'h3);
      bus(6'h08, 1'b1, ~rnd, 4'h1);
      rd(6'h08, {26'h0, rnd[17:16], ctl, 1'b0}, "ctrl");
      chk("outs", {29'h0, ctl}, {29'h0, frc, pws, lpb});
    end
    $display("test controls done");
    bus(6'h1C, 1'b1, 32'h1, 4'h1);
    bus(6'h18, 1'b1, 32'h7, 4'h1);
    for (int r = 0; r < 4; r++)
    begin
      rnd = lfsr(rnd);
      bus(6'h00, 1'b1, {rnd[31:16], 1'b1, rnd[14:0]}, 4'h3);
      bus(6'h00, 1'b0, 32'h0, 4'hF);
      chk("busy", 32'h1, {31'h0, rdat[15]});
      bus(6'h00, 1'b1, 32'h8000, 4'h3);
      res <= pcd_result_e'(r[1:0]);
      {ns, cnt} <= {rnd[20], rnd[8:0]};
      @(posedge clk_sys) done <= 1'b1;
      @(posedge clk_sys) done <= 1'b0;
      rd(6'h00, {17'h0, r[1:0], rnd[20] && r == 2, 3'h0, rnd[8:0]}, "cable");
      rd(6'h10, {16'h0, rnd[20] && r == 2, r[1:0], 1'b0, ctl, rnd[8:0]}, "alias diag");
      chk("start pulses", r + 1, starts);
      chk("irq set", 32'h1, {31'h0, irq});
      bus(6'h18, 1'b1, 32'h1, 4'h1);
      @(posedge clk_sys);
      chk("irq clear", 32'h0, {31'h0, irq});
      rd(6'h18, 32'h0, "irq status");
    end
    $display("test diagnostic done");
    bus(6'h10, 1'b1, {19'h0, 1'b1, ctl, 9'h0}, 4'h3);
    repeat (60) @(posedge clk_sys);
    rd(6'h00, 32'h6000, "watchdog");
    chk("start watchdog", 32'h5, starts);
    chk("irq timeout", 32'h1, {31'h0, irq});
    $display("test watchdog done");
    end_of_test();
  end
endmodule
`default_nettype wire

/* File: tb/pcd_regs_sva.sv */
// Checker for the cable diagnostic register bank.
// Assumes a classic single-cycle Wishbone master.
`timescale 1ns/1ns
`default_nettype none
module pcd_regs_chk (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [5:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Engine and controls
  input wire logic        testStart,
  input wire logic        forceLinkPass,
  input wire logic        powerSaveDisable,
  input wire logic        lineLoopback
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_land;
    wb_cyc_i && wb_stb_i && wb_ack_o;
  endsequence
  sequence s_wr(logic [3:0] idx);
    s_land ##0 (wb_we_i && wb_sel_i[1:0] == 2'h3 && wb_adr_i[5:2] == idx);
  endsequence
  a_ack_resp: assert property (s_take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse after request");
  a_start_pulse: assert property (testStart |=> !testStart)
    else $error("start pulse too long");
  a_start_cause: assert property (testStart |-> $past(wb_ack_o && wb_we_i))
    else $error("start without a write");
  a_reset_vals: assert property ($fell(rst) |-> powerSaveDisable && !forceLinkPass && !lineLoopback)
    else $error("control reset values wrong");
  a_ctl_hold: assert property (!$stable({forceLinkPass, powerSaveDisable, lineLoopback}) |-> $past(wb_ack_o && wb_we_i))
    else $error("control changed without a write");
  a_ctl_write: assert property (s_wr(4'h2) |=> {forceLinkPass, powerSaveDisable, lineLoopback} == $past(wb_dat_i[3:1]))
    else $error("control write not applied");
  a_alias_write: assert property (s_wr(4'h4) |=> {forceLinkPass, powerSaveDisable, lineLoopback} == $past(wb_dat_i[11:9]))
    else $error("alias write not applied");
  a_rd_ctl: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i[5:2] == 4'h2) |->
    wb_dat_o == {26'h0, wb_dat_o[5:4], forceLinkPass, powerSaveDisable, lineLoopback, 1'h0})
    else $error("control read wrong");
  a_rd_alias: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i[5:2] == 4'h4) |->
    wb_dat_o[31:16] == 16'h0 && wb_dat_o[11:9] == {forceLinkPass, powerSaveDisable, lineLoopback})
    else $error("alias read wrong");
endmodule
bind pcd_regs pcd_regs_chk chk (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .testStart, .forceLinkPass, .powerSaveDisable, .lineLoopback);
`default_nettype wire
